// ===== pkg/touch_cfg_pkg.sv
// constants, field layouts and types for the touch LED configuration registers
// assumes one 40 MHz system clock and a serial management link of two pins
package touch_cfg_pkg;

  // register offsets
  localparam logic [7:0] OFS_MODE      = 8'h00;
  localparam logic [7:0] OFS_LED_CTRL  = 8'h01;

  // reset values
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [7:0] LED_CTRL_RST  = 8'h00;
  localparam logic [7:0] RSVD_READ     = 8'h00;

  // device mode codes
  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'h0,
    MODE_LED_SETUP = 3'h1,
    MODE_DEV_SETUP = 3'h2,
    MODE_PROD_TEST = 3'h3,
    MODE_DEBUG     = 3'h4
  } dev_mode_e;
  localparam logic [2:0] MODE_LAST_VALID = 3'h4;
  localparam int         MODE_W          = 3;

  // led_effect_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic       last_only;
    logic       analog_en;
    logic [1:0] standby_lvl;
    logic       hold_en;
    logic       touch_en;
    logic       pwron_en;
    logic       pwron_seq;
  } led_ctrl_s;

  // standby duty in percent per code
  localparam logic [6:0] DUTY_CODE0 = 7'h00;
  localparam logic [6:0] DUTY_CODE1 = 7'h14;
  localparam logic [6:0] DUTY_CODE2 = 7'h1E;
  localparam logic [6:0] DUTY_CODE3 = 7'h32;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int FADE_STEP_MS  = 20;
  localparam int FADE_STEP_CYC = (FADE_STEP_MS * 1000000) / CLK_PERIOD_NS;

  // link framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT_IDX  = 4'h7;
  localparam logic [6:0] DEV_ADDR_DEF  = 7'h37;

  // outputs grouped toward the effect engine
  typedef struct packed {
    logic [2:0] mode;
    logic       analog_en;
    logic [6:0] standby_duty;
  } cfg_out_s;

endpackage

// ===== verilog/pin_sync.sv
// three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync
  import touch_cfg_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_reg <= RESET_LEVEL;
      s2_reg <= RESET_LEVEL;
      s3_reg <= RESET_LEVEL;
      level  <= RESET_LEVEL;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end

endmodule

// ===== verilog/touch_led_mode_config_regs.sv
// mode selector and global LED effect control registers behind the serial link
// assumes buttons and power-on start arrive on ref_clk; scl/sda are external pins
// Notes on behaviour
// - registers take documented values at reset
// - reserved offsets read zero, writes dropped
// - three-bit mode, codes five to seven refused
// - bit 7 limits touch effects to last touched
// - bit 6 enables analog-voltage output use
// - bits 5:4 give standby duty 0/20/30/50
// - bit 3 holds LED after release
// - bit 2 gates touch effect settings
// - bit 1 gates power-on effect settings
// - bit 0 runs power-on outputs in order
// - each fade unit adds 20 ms
`timescale 1ns/1ps
module touch_led_mode_config_regs
  import touch_cfg_pkg::*;
#(
  parameter int         NUM_OUT   = 10,
  parameter int         STEP_CYC  = FADE_STEP_CYC,
  parameter logic [6:0] DEV_ADDR  = DEV_ADDR_DEF
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  input  wire logic [NUM_OUT-1:0] button_in,
  input  wire logic               poweron_start,
  input  wire logic [7:0]         fade_period_one,
  output cfg_out_s                cfg_out,
  output logic [NUM_OUT-1:0]      led_on,
  output logic [NUM_OUT-1:0]      touch_effect_run,
  output logic [NUM_OUT-1:0]      poweron_effect_run
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_AACK   = 3'b011,
    ST_RX     = 3'b010,
    ST_RACK   = 3'b110,
    ST_TX     = 3'b111,
    ST_TACK   = 3'b101
  } link_e;
  localparam int          CNT_W    = $clog2(STEP_CYC + 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);
  localparam int          IDX_W    = $clog2(NUM_OUT + 1);
  // pin synchronisers
  logic scl_lvl;
  logic sda_lvl;
  logic scl_prev_reg;
  logic sda_prev_reg;
  pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (scl_in),
    .level   (scl_lvl)
  );
  pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (sda_in),
    .level   (sda_lvl)
  );
  // link state
  link_e      state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic       read_reg;
  logic       ptr_phase_reg;
  logic       nack_reg;
  logic [7:0] ptr_reg;
  // register contents
  logic [2:0] mode_reg;
  led_ctrl_s  ctrl_reg;
  wire start_cond = scl_lvl & sda_prev_reg & ~sda_lvl;
  wire stop_cond  = scl_lvl & ~sda_prev_reg & sda_lvl;
  wire scl_rise   = scl_lvl & ~scl_prev_reg;
  wire scl_fall   = ~scl_lvl & scl_prev_reg;
  wire byte_full  = (bit_cnt_reg == BITS_PER_BYTE);
  wire addr_match = (shift_reg[7:1] == DEV_ADDR);
  wire       wr_strobe   = (state_reg == ST_RX) & scl_fall & byte_full & ~ptr_phase_reg;
  wire       wr_mode     = wr_strobe & (ptr_reg == OFS_MODE);
  wire       wr_ctrl     = wr_strobe & (ptr_reg == OFS_LED_CTRL);
  wire       mode_legal  = (shift_reg[2:0] <= MODE_LAST_VALID);
  wire [7:0] rd_data     = (ptr_reg == OFS_MODE)     ? {5'h00, mode_reg} :
                           (ptr_reg == OFS_LED_CTRL) ? ctrl_reg : RSVD_READ;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_lvl;
      sda_prev_reg <= sda_lvl;
    end
  end
  // link state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      read_reg      <= 1'b0;
      ptr_phase_reg <= 1'b0;
      nack_reg      <= 1'b0;
      ptr_reg       <= 8'h00;
      sda_oe_n      <= 1'b1;
    end else if (start_cond) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_n    <= 1'b1;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
      sda_oe_n  <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_lvl};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            if (addr_match) begin
              read_reg  <= shift_reg[0];
              sda_oe_n  <= 1'b0;
              state_reg <= ST_AACK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (read_reg) begin
              shift_reg <= rd_data;
              sda_oe_n  <= rd_data[7];
              ptr_reg   <= ptr_reg + 8'h01;
              state_reg <= ST_TX;
            end else begin
              sda_oe_n      <= 1'b1;
              ptr_phase_reg <= 1'b1;
              state_reg     <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_lvl};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_full) begin
            sda_oe_n  <= 1'b0;
            state_reg <= ST_RACK;
            if (ptr_phase_reg) begin
              ptr_reg <= shift_reg;
            end else begin
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_oe_n      <= 1'b1;
            ptr_phase_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
            state_reg     <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_BIT_IDX) begin
              sda_oe_n  <= 1'b1;
              state_reg <= ST_TACK;
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_oe_n    <= shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            nack_reg <= sda_lvl;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              shift_reg   <= rd_data;
              sda_oe_n    <= rd_data[7];
              ptr_reg     <= ptr_reg + 8'h01;
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_TX;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe_n  <= 1'b1;
        end
      endcase
    end
  end
  // register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
      ctrl_reg <= LED_CTRL_RST;
      sda_out  <= 1'b0;
    end else begin
      if (wr_mode && mode_legal) begin
        mode_reg <= shift_reg[2:0];
      end
      if (wr_ctrl) begin
        ctrl_reg <= shift_reg;
      end
    end
  end
  wire [6:0] duty_sel = (ctrl_reg.standby_lvl == 2'h0) ? DUTY_CODE0 :
                        (ctrl_reg.standby_lvl == 2'h1) ? DUTY_CODE1 :
                        (ctrl_reg.standby_lvl == 2'h2) ? DUTY_CODE2 : DUTY_CODE3;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_out <= '0;
    end else begin
      cfg_out.mode         <= mode_reg;
      cfg_out.analog_en    <= ctrl_reg.analog_en;
      cfg_out.standby_duty <= duty_sel;
    end
  end
  // 20 ms step tick
  logic [CNT_W-1:0] step_cnt_reg;
  wire              step_tick = (step_cnt_reg == STEP_LAST);
  always_ff @(posedge ref_clk) begin
    if (rst || step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + CNT_W'(1);
    end
  end
  // last touched button
  logic [NUM_OUT-1:0] btn_prev_reg;
  logic [IDX_W-1:0]   last_idx_reg;
  logic [IDX_W-1:0]   rise_idx;
  logic               any_rise;
  always_comb begin
    rise_idx = last_idx_reg;
    any_rise = 1'b0;
    for (int k = 0; k < NUM_OUT; k++) begin
      if (button_in[k] && !btn_prev_reg[k]) begin
        rise_idx = IDX_W'(k);
        any_rise = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      btn_prev_reg <= '0;
      last_idx_reg <= '0;
    end else begin
      btn_prev_reg <= button_in;
      if (any_rise) begin
        last_idx_reg <= rise_idx;
      end
    end
  end
  // power-on sequencing
  logic [7:0]       po_wait_reg;
  logic [IDX_W-1:0] po_next_reg;
  logic             po_active_reg;
  wire  [7:0]       po_step_len = (fade_period_one == 8'h00) ? 8'h01 : fade_period_one;
  wire              po_advance  = po_active_reg & step_tick & (po_wait_reg == 8'h01);
  always_ff @(posedge ref_clk) begin
    if (rst || !ctrl_reg.pwron_en) begin
      poweron_effect_run <= '0;
      po_active_reg      <= 1'b0;
      po_next_reg        <= '0;
      po_wait_reg        <= 8'h00;
    end else if (poweron_start) begin
      if (ctrl_reg.pwron_seq) begin
        poweron_effect_run <= NUM_OUT'(1);
        po_next_reg        <= IDX_W'(1);
        po_wait_reg        <= po_step_len;
        po_active_reg      <= (NUM_OUT > 1);
      end else begin
        poweron_effect_run <= '1;
        po_active_reg      <= 1'b0;
      end
    end else if (po_advance) begin
      poweron_effect_run[po_next_reg] <= 1'b1;
      po_next_reg   <= po_next_reg + IDX_W'(1);
      po_wait_reg   <= po_step_len;
      po_active_reg <= (po_next_reg != IDX_W'(NUM_OUT - 1));
    end else if (po_active_reg && step_tick) begin
      po_wait_reg <= po_wait_reg - 8'h01;
    end
  end
  // per-output hold and effect gating
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic [7:0] hold_reg;
      wire        released = btn_prev_reg[g] & ~button_in[g];
      wire        in_scope = ~ctrl_reg.last_only | (last_idx_reg == IDX_W'(g));
      wire        held     = released & ctrl_reg.hold_en & (fade_period_one != 8'h00);
      wire        lit      = button_in[g] | held | (hold_reg != 8'h00);
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          hold_reg <= 8'h00;
        end else if (button_in[g] || !ctrl_reg.hold_en) begin
          hold_reg <= 8'h00;
        end else if (released) begin
          hold_reg <= fade_period_one;
        end else if (step_tick && hold_reg != 8'h00) begin
          hold_reg <= hold_reg - 8'h01;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          led_on[g]           <= 1'b0;
          touch_effect_run[g] <= 1'b0;
        end else begin
          led_on[g]           <= lit;
          touch_effect_run[g] <= ctrl_reg.touch_en & in_scope & lit;
        end
      end
    end
  endgenerate
endmodule

// ===== dv/touch_cfg_asserts.sv
// assertions on the configuration register block ports
// assumes bind to touch_led_mode_config_regs
`timescale 1ns/1ps
module touch_cfg_asserts
  import touch_cfg_pkg::*;
#(
  parameter int NUM_OUT  = 10,
  parameter int STEP_CYC = 20
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               sda_oe_n,
  input wire logic [NUM_OUT-1:0] button_in,
  input wire logic               poweron_start,
  input wire logic [7:0]         fade_period_one,
  input wire cfg_out_s           cfg_out,
  input wire logic [NUM_OUT-1:0] led_on,
  input wire logic [NUM_OUT-1:0] touch_effect_run,
  input wire logic [NUM_OUT-1:0] poweron_effect_run
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] idle_cnt;
  // cycles with an LED lit and no button touched
  always_ff @(posedge ref_clk)
    if (rst || led_on == '0 || button_in != '0) idle_cnt <= '0;
    else idle_cnt <= idle_cnt + 32'h1;
  property p_rst;
    $fell(rst) |-> cfg_out == '0 && led_on == '0 && poweron_effect_run == '0 && sda_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_mode;
    cfg_out.mode <= MODE_LAST_VALID;
  endproperty
  a_mode: assert property (p_mode) else $error("invalid mode code held");
  property p_duty;
    cfg_out.standby_duty inside {7'h00, 7'h14, 7'h1E, 7'h32};
  endproperty
  a_duty: assert property (p_duty) else $error("standby duty off table");
  property p_touch;
    (touch_effect_run & ~led_on) == '0;
  endproperty
  a_touch: assert property (p_touch) else $error("touch effect on unlit output");
  property p_press;
    !$past(rst) |-> (led_on & $past(button_in)) == $past(button_in);
  endproperty
  a_press: assert property (p_press) else $error("touched output not lit");
  property p_order;
    ((poweron_effect_run + 32'h1) & poweron_effect_run) == '0;
  endproperty
  a_order: assert property (p_order) else $error("power-on outputs out of order");
  property p_pwr;
    $rose(poweron_effect_run[0]) |-> $past(poweron_start) || $past(poweron_start, 2);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-on effect without start");
  property p_hold;
    idle_cnt <= (fade_period_one + 32'h1) * STEP_CYC + 2;
  endproperty
  a_hold: assert property (p_hold) else $error("hold time too long");
endmodule

// ===== dv/link_host.sv
// serial link master driving clock and data of the register link
// assumes a pull-up on data: sda_m high releases the line
`timescale 1ns/1ps
module link_host #(
  parameter int HP = 6
) (
  input  wire logic ref_clk,
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic ph(input logic c, input logic d);
    repeat (HP) @(posedge ref_clk);
    scl <= c;
    sda_m <= d;
  endtask
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, sda_m);
    ph(1'b0, b);
    ph(1'b1, b);
    ph(1'b1, b);
    r = sda;
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask
  task automatic stop();
    ph(1'b0, sda_m);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] o, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    ph(1'b1, 1'b0);
    xfer({dev, 1'b0}, 1'b1, q, a[2]);
    xfer(o, 1'b1, q, a[1]);
    xfer(d, 1'b1, q, a[0]);
    stop();
    ok = (a == 3'h0);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] o, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    ph(1'b1, 1'b0);
    xfer({dev, 1'b0}, 1'b1, q, a[2]);
    xfer(o, 1'b1, q, a[1]);
    stop();
    ph(1'b1, 1'b0);
    xfer({dev, 1'b1}, 1'b1, q, a[0]);
    xfer(8'hFF, 1'b1, d, ok);
    stop();
    ok = (a == 3'h0);
  endtask
endmodule

// ===== dv/touch_led_mode_config_regs_tb.sv
// bench for the mode and LED effect control registers
// assumes link_host and the checker are compiled first
`timescale 1ns/1ps
module touch_led_mode_config_regs_tb;
  import touch_cfg_pkg::*;
  logic       ref_clk;
  logic       rst;
  logic       scl;
  logic       sda_m;
  wire        sda;
  logic       sda_out;
  logic       sda_oe_n;
  logic [9:0] button_in;
  logic       poweron_start;
  logic [7:0] fade_period_one;
  cfg_out_s   cfg_out;
  logic [9:0] led_on;
  logic [9:0] touch_effect_run;
  logic [9:0] poweron_effect_run;
  int         num_errors;
  int         samples_checked;
  int         seed;
  logic [7:0] v;
  logic [7:0] ctl;
  logic [7:0] ofs;
  logic [9:0] b;
  logic [2:0] mode;
  logic       ok;
  assign sda = sda_m & (sda_oe_n | sda_out);
  touch_led_mode_config_regs #(.STEP_CYC(20)) dut_u (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .button_in(button_in),
    .poweron_start(poweron_start), .fade_period_one(fade_period_one), .cfg_out(cfg_out),
    .led_on(led_on), .touch_effect_run(touch_effect_run), .poweron_effect_run(poweron_effect_run));
  link_host host_u (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    host_u.wr(DEV_ADDR_DEF, o, d, ok);
    chk(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] o);
    host_u.rd(DEV_ADDR_DEF, o, v, ok);
    chk(ok, 1'b1);
  endtask
  task automatic press(input logic [9:0] p);
    @(posedge ref_clk);
    button_in <= p;
    wt(2);
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    poweron_start <= 1'b1;
    @(posedge ref_clk);
    poweron_start <= 1'b0;
    wt(2);
  endtask
  function automatic logic [6:0] duty(input logic [1:0] c);
    return (c == 2'h0) ? 7'h00 : (c == 2'h1) ? 7'h14 : (c == 2'h2) ? 7'h1E : 7'h32;
  endfunction
  initial begin
    cyc_guard();
  end
  task automatic cyc_guard();
    repeat (95000) @(posedge ref_clk);
    num_errors++;
    $display("FAIL %0t timeout", $time);
    close_out();
  endtask
  initial begin
    seed = 32'h3825051F;
    mode = 3'h0;
    rst <= 1'b1;
    button_in <= '0;
    poweron_start <= 1'b0;
    fade_period_one <= 8'h03;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    wt(4);
    chk(cfg_out, '0);
    rd(OFS_LED_CTRL);
    chk(v, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_MODE, 8'(c));
      if (c < 5) mode = 3'(c);
      rd(OFS_MODE);
      chk(v, {5'h00, mode});
      chk(cfg_out.mode, mode);
    end
    for (int c = 0; c < 4; c++) begin
      ctl = 8'($random(seed));
      ctl[5:4] = 2'(c);
      wr(OFS_LED_CTRL, ctl);
      rd(OFS_LED_CTRL);
      chk(v, ctl);
      chk(cfg_out.analog_en, ctl[6]);
      chk(cfg_out.standby_duty, duty(ctl[5:4]));
    end
    repeat (2) begin
      ofs = 8'($random(seed));
      ofs[1] = 1'b1;
      wr(ofs, 8'hFF);
      rd(ofs);
      chk(v, RSVD_READ);
    end
    host_u.wr(7'h12, OFS_LED_CTRL, 8'h00, ok);
    chk(ok, 1'b0);
    rd(OFS_LED_CTRL);
    chk(v, ctl);
    wr(OFS_LED_CTRL, 8'h04);
    repeat (3) begin
      b = 10'($random(seed));
      press(b);
      chk(touch_effect_run, b);
    end
    press(10'h000);
    wr(OFS_LED_CTRL, 8'h84);
    press(10'h004);
    press(10'h024);
    chk(touch_effect_run, 10'h020);
    wr(OFS_LED_CTRL, 8'h00);
    chk(touch_effect_run, 10'h000);
    press(10'h000);
    chk(led_on, 10'h000);
    wr(OFS_LED_CTRL, 8'h08);
    press(10'h010);
    @(posedge ref_clk);
    button_in <= '0;
    wt(1);
    chk(led_on, 10'h010);
    wt(37);
    chk(led_on, 10'h010);
    wt(26);
    chk(led_on, 10'h000);
    @(posedge ref_clk);
    fade_period_one <= 8'h00;
    press(10'h010);
    press(10'h000);
    chk(led_on, 10'h000);
    @(posedge ref_clk);
    fade_period_one <= 8'h02;
    wr(OFS_LED_CTRL, 8'h02);
    pulse();
    chk(poweron_effect_run, 10'h3FF);
    wr(OFS_LED_CTRL, 8'h03);
    pulse();
    chk(poweron_effect_run, 10'h001);
    wt(450);
    chk(poweron_effect_run, 10'h3FF);
    wr(OFS_LED_CTRL, 8'h01);
    pulse();
    chk(poweron_effect_run, 10'h000);
    close_out();
  end
endmodule
bind touch_led_mode_config_regs touch_cfg_asserts #(.NUM_OUT(NUM_OUT), .STEP_CYC(STEP_CYC)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .sda_oe_n(sda_oe_n), .button_in(button_in),
  .poweron_start(poweron_start), .fade_period_one(fade_period_one), .cfg_out(cfg_out),
  .led_on(led_on), .touch_effect_run(touch_effect_run), .poweron_effect_run(poweron_effect_run));
